/* File: hw/cqc_channel_ctrl.sv */
// Purpose: Channel control register, link setup sequencer, send control
// Assumes: Framer, queues and host port decode share ref_clk
// Notes:   Rate probing tries the fastest rate first and relies on the
//          framer answering every probe
`timescale 1ns/1ns
`default_nettype none
module cqc_channel_ctrl #(
    parameter int WURQ_CYCLES = cqc_pkg::CQC_WURQ_CYCLES,
    parameter int TIMER_W = cqc_pkg::CQC_TIMER_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Framer side
    input wire logic framer_enable_bit,
    input wire logic tx_queue_empty,
    input wire logic tx_shift_busy,
    input wire logic trigger_cmd,
    input wire cqc_pkg::cqc_probe_rsp_t probe_rsp,
    output cqc_pkg::cqc_probe_req_t probe_req,
    // Queue commands
    output logic transmit_queue_clear,
    output logic receive_queue_clear,
    // Line driver
    output cqc_pkg::cqc_line_t line,
    // Cycle timer
    input wire logic [TIMER_W-1:0] cycle_period,
    output logic timer_running,
    output logic cycle_tick,
    // Status
    output logic wakeup_done_interrupt,
    output logic [7:0] device_cycle_time_reg
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        cqc_pkg::cqc_ctrl_t ctrl;
        cqc_pkg::cqc_seq_t seq;
        logic [1:0] try_rate;
        logic tx_active;
        logic irq;
        logic probe_start;
        logic [7:0] cyc_time;
        logic [7:0] rdata;
    } cqc_main_state_t;

    cqc_main_state_t s_q;
    cqc_main_state_t s_d;
    logic wake_start;
    logic timer_start;
    logic wk_active;
    logic wk_done;
    logic wr_hit;
    logic idle_ok;
    logic tx_finished;

    assign wr_hit = reg_wr && (reg_addr == cqc_pkg::CQC_CTRL_OFFSET);
    // Nothing else may own the line while a new action begins
    assign idle_ok = (s_q.seq == cqc_pkg::SEQ_IDLE) && !wk_active &&
                     !s_q.tx_active;
    assign tx_finished = s_q.tx_active && tx_queue_empty &&
                         !tx_shift_busy && !s_q.ctrl.msg_send;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        wake_start = 1'b0;
        timer_start = 1'b0;
        s_d.irq = 1'b0;
        s_d.probe_start = 1'b0;
        s_d.ctrl.msg_send = 1'b0;
        s_d.ctrl.txq_clear = 1'b0;
        s_d.ctrl.rxq_clear = 1'b0;

        if (s_q.ctrl.wakeup_req && wk_done) begin
            s_d.ctrl.wakeup_req = 1'b0;
        end
        if (tx_finished) begin
            s_d.tx_active = 1'b0;
        end

        if (wr_hit) begin
            // Rate field is owned by the sequencer while it runs
            if (s_q.seq == cqc_pkg::SEQ_IDLE) begin
                s_d.ctrl.rate = reg_wdata[cqc_pkg::CQC_BIT_RATE_HI:
                                          cqc_pkg::CQC_BIT_RATE_LO];
            end
            s_d.ctrl.timer_arm = reg_wdata[cqc_pkg::CQC_BIT_ARM];
            if (reg_wdata[cqc_pkg::CQC_BIT_TXCLR]) begin
                s_d.ctrl.txq_clear = 1'b1;
            end
            if (reg_wdata[cqc_pkg::CQC_BIT_RXCLR]) begin
                s_d.ctrl.rxq_clear = 1'b1;
            end
            if (reg_wdata[cqc_pkg::CQC_BIT_SETUP] && idle_ok &&
                    framer_enable_bit) begin
                s_d.ctrl.setup_start = 1'b1;
                s_d.seq = cqc_pkg::SEQ_WAKE;
                wake_start = 1'b1;
            end else if (reg_wdata[cqc_pkg::CQC_BIT_WAKE] && idle_ok) begin
                s_d.ctrl.wakeup_req = 1'b1;
                wake_start = 1'b1;
            end else if (reg_wdata[cqc_pkg::CQC_BIT_SEND] && idle_ok) begin
                s_d.ctrl.msg_send = 1'b1;
                s_d.tx_active = 1'b1;
                timer_start = s_q.ctrl.timer_arm;
            end
        end

        unique case (s_q.seq)
            cqc_pkg::SEQ_IDLE: begin
            end
            cqc_pkg::SEQ_WAKE: begin
                if (wk_done) begin
                    s_d.seq = cqc_pkg::SEQ_PROBE;
                    s_d.try_rate = cqc_pkg::CQC_RATE_COM3;
                end
            end
            cqc_pkg::SEQ_PROBE: begin
                s_d.probe_start = 1'b1;
                s_d.seq = cqc_pkg::SEQ_WAIT;
            end
            cqc_pkg::SEQ_WAIT: begin
                if (probe_rsp.done) begin
                    if (probe_rsp.ok) begin
                        s_d.ctrl.rate = s_q.try_rate;
                        s_d.cyc_time = probe_rsp.cycle_time;
                        s_d.ctrl.setup_start = 1'b0;
                        s_d.irq = 1'b1;
                        s_d.seq = cqc_pkg::SEQ_IDLE;
                    end else if (s_q.try_rate == cqc_pkg::CQC_RATE_COM1) begin
                        s_d.ctrl.rate = cqc_pkg::CQC_RATE_FAIL;
                        s_d.ctrl.setup_start = 1'b0;
                        s_d.irq = 1'b1;
                        s_d.seq = cqc_pkg::SEQ_IDLE;
                    end else begin
                        s_d.try_rate = s_q.try_rate - 2'h1;
                        s_d.seq = cqc_pkg::SEQ_PROBE;
                    end
                end
            end
        endcase

        // Read data is captured so the host port sees a stable byte
        if (reg_rd) begin
            if (reg_addr == cqc_pkg::CQC_CTRL_OFFSET) begin
                s_d.rdata = s_q.ctrl;
            end else begin
                s_d.rdata = cqc_pkg::CQC_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.ctrl <= cqc_pkg::CQC_CTRL_RESET;
            s_q.seq <= cqc_pkg::SEQ_IDLE;
            s_q.cyc_time <= cqc_pkg::CQC_CYC_TIME_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Wake-up pulse and cycle timer
    // ************************************************************
    cqc_wakeup #(
        .CYCLES(WURQ_CYCLES)
    ) u_wakeup (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(wake_start),
        .active(wk_active),
        .done(wk_done)
    );

    cqc_cycle_timer #(
        .W(TIMER_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .arm(s_q.ctrl.timer_arm),
        .start(timer_start || trigger_cmd),
        .period(cycle_period),
        .running(timer_running),
        .tick(cycle_tick)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata = s_q.rdata;
    assign transmit_queue_clear = s_q.ctrl.txq_clear;
    assign receive_queue_clear = s_q.ctrl.rxq_clear;
    assign wakeup_done_interrupt = s_q.irq;
    assign device_cycle_time_reg = s_q.cyc_time;
    assign probe_req.start = s_q.probe_start;
    assign probe_req.rate = s_q.try_rate;
    assign line.tx_mode = s_q.tx_active;
    assign line.wakeup_drive = wk_active;
    assign line.rx_mode = !s_q.tx_active && !wk_active;
    assign line.climit_boost = wk_active && s_q.ctrl.setup_start;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_setup_wake_start: assert property (
        wr_hit && reg_wdata[cqc_pkg::CQC_BIT_SETUP] && idle_ok &&
        framer_enable_bit |=> wk_active && s_q.ctrl.setup_start)
        else $error("setup write did not start wake-up");
    a_setup_ok_done: assert property (
        s_q.seq == cqc_pkg::SEQ_WAIT && probe_rsp.done && probe_rsp.ok
        |=> wakeup_done_interrupt && !s_q.ctrl.setup_start)
        else $error("setup success not reported");
    a_boost_setup_only: assert property (
        line.climit_boost ==
        (line.wakeup_drive && s_q.seq == cqc_pkg::SEQ_WAKE))
        else $error("current boost wrong during wake-up");
    a_ok_rate_kept: assert property (
        s_q.seq == cqc_pkg::SEQ_WAIT && probe_rsp.done && probe_rsp.ok
        |=> s_q.ctrl.rate == $past(s_q.try_rate) &&
            device_cycle_time_reg == $past(probe_rsp.cycle_time))
        else $error("detected rate or cycle time not stored");
    a_fail_rate_zero: assert property (
        s_q.seq == cqc_pkg::SEQ_WAIT && probe_rsp.done && !probe_rsp.ok &&
        s_q.try_rate == cqc_pkg::CQC_RATE_COM1
        |=> wakeup_done_interrupt && s_q.ctrl.rate == cqc_pkg::CQC_RATE_FAIL
            && !s_q.ctrl.setup_start)
        else $error("setup failure not reported");
    a_host_wake_drive: assert property (
        wr_hit && reg_wdata[cqc_pkg::CQC_BIT_WAKE] && idle_ok &&
        !reg_wdata[cqc_pkg::CQC_BIT_SETUP]
        |=> line.wakeup_drive && !line.climit_boost)
        else $error("host wake-up not driven");
    a_wake_bit_clear: assert property (
        s_q.ctrl.wakeup_req && wk_done |=> !s_q.ctrl.wakeup_req && line.rx_mode)
        else $error("wake-up bit not cleared");
    a_txq_clear_pulse: assert property (
        wr_hit && reg_wdata[cqc_pkg::CQC_BIT_TXCLR]
        |=> transmit_queue_clear ##1 !transmit_queue_clear)
        else $error("transmit queue clear not one-shot");
    a_rxq_clear_pulse: assert property (
        wr_hit && reg_wdata[cqc_pkg::CQC_BIT_RXCLR]
        |=> receive_queue_clear ##1 !receive_queue_clear)
        else $error("receive queue clear not one-shot");
    a_arm_no_start: assert property (
        wr_hit && reg_wdata[cqc_pkg::CQC_BIT_ARM] && !timer_running &&
        !reg_wdata[cqc_pkg::CQC_BIT_SEND] && !trigger_cmd
        |=> !timer_running)
        else $error("arming alone started the timer");
    a_trigger_start: assert property (
        s_q.ctrl.timer_arm && trigger_cmd |=> timer_running)
        else $error("trigger did not start armed timer");
    a_disarm_stop: assert property (
        wr_hit && !reg_wdata[cqc_pkg::CQC_BIT_ARM] |=> ##1 !timer_running)
        else $error("timer kept running after disarm");
    a_send_tx_mode: assert property (
        wr_hit && reg_wdata[cqc_pkg::CQC_BIT_SEND] && idle_ok &&
        !reg_wdata[cqc_pkg::CQC_BIT_SETUP] && !reg_wdata[cqc_pkg::CQC_BIT_WAKE]
        |=> line.tx_mode && !line.rx_mode ##1 !s_q.ctrl.msg_send)
        else $error("send did not enter transmit mode");
    a_tx_turnaround: assert property (
        tx_finished |=> line.rx_mode)
        else $error("no receive mode after message");
    a_send_self_clear: assert property (
        s_q.ctrl.msg_send |=> !s_q.ctrl.msg_send)
        else $error("send bit did not clear itself");
    a_wake_bit_hold: assert property (
        s_q.ctrl.wakeup_req && !wk_done |=> s_q.ctrl.wakeup_req)
        else $error("wake-up bit cleared before pulse end");
    a_wake_rx_after: assert property (
        $fell(line.wakeup_drive) && s_q.ctrl.wakeup_req
        |-> line.rx_mode && !line.tx_mode)
        else $error("no receive mode after host wake-up");
    a_probe_fast_first: assert property (
        s_q.seq == cqc_pkg::SEQ_WAKE && wk_done
        |=> ##1 probe_req.start &&
            probe_req.rate == cqc_pkg::CQC_RATE_COM3)
        else $error("rate detection did not follow wake-up");
    a_rate_held_busy: assert property (
        s_q.seq == cqc_pkg::SEQ_WAKE || s_q.seq == cqc_pkg::SEQ_PROBE
        |=> $stable(s_q.ctrl.rate))
        else $error("rate field changed during setup");
    a_send_arm_start: assert property (
        wr_hit && reg_wdata[cqc_pkg::CQC_BIT_SEND] && idle_ok &&
        !reg_wdata[cqc_pkg::CQC_BIT_SETUP] &&
        !reg_wdata[cqc_pkg::CQC_BIT_WAKE] && s_q.ctrl.timer_arm &&
        reg_wdata[cqc_pkg::CQC_BIT_ARM] |=> timer_running)
        else $error("send did not start armed timer");
    a_irq_one_shot: assert property (
        wakeup_done_interrupt |=> !wakeup_done_interrupt)
        else $error("wake-up done interrupt longer than one cycle");

    c_setup_ok: cover property (
        s_q.seq == cqc_pkg::SEQ_WAIT && probe_rsp.done && probe_rsp.ok);
    c_setup_fail: cover property (
        wakeup_done_interrupt && s_q.ctrl.rate == cqc_pkg::CQC_RATE_FAIL);
    c_send_timer: cover property (timer_start ##1 timer_running);
    c_tx_turn: cover property (line.tx_mode ##1 line.rx_mode);
    c_host_wake: cover property (s_q.ctrl.wakeup_req && wk_done);
endmodule
`default_nettype wire

/* File: inc/cqc_pkg.sv */
// Purpose: Shared constants and carriers for the line channel control block
// Assumes: 100 MHz ref_clk, one channel
// Notes:   Control register bit order follows cqc_ctrl_t from bit 7 down
package cqc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CQC_CTRL_OFFSET = 8'h06;
    localparam logic [7:0] CQC_CTRL_RESET = 8'h00;
    localparam logic [7:0] CQC_UNMAPPED_READ = 8'h00;
    localparam int CQC_BIT_SEND = 0;
    localparam int CQC_BIT_ARM = 1;
    localparam int CQC_BIT_RXCLR = 2;
    localparam int CQC_BIT_TXCLR = 3;
    localparam int CQC_BIT_WAKE = 4;
    localparam int CQC_BIT_SETUP = 5;
    localparam int CQC_BIT_RATE_LO = 6;
    localparam int CQC_BIT_RATE_HI = 7;

    // ************************************************************
    // Rate codes
    // ************************************************************
    localparam logic [1:0] CQC_RATE_FAIL = 2'h0;
    localparam logic [1:0] CQC_RATE_COM1 = 2'h1;
    localparam logic [1:0] CQC_RATE_COM2 = 2'h2;
    localparam logic [1:0] CQC_RATE_COM3 = 2'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CQC_CLK_PERIOD_NS = 10;
    localparam int CQC_WURQ_TIME_NS = 80000;
    localparam int CQC_WURQ_CYCLES = CQC_WURQ_TIME_NS / CQC_CLK_PERIOD_NS;
    localparam int CQC_TIMER_W = 16;
    localparam logic [7:0] CQC_CYC_TIME_RESET = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [1:0] rate;
        logic setup_start;
        logic wakeup_req;
        logic txq_clear;
        logic rxq_clear;
        logic timer_arm;
        logic msg_send;
    } cqc_ctrl_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAKE,
        SEQ_PROBE,
        SEQ_WAIT
    } cqc_seq_t;

    typedef struct packed {
        logic tx_mode;
        logic rx_mode;
        logic wakeup_drive;
        logic climit_boost;
    } cqc_line_t;

    typedef struct packed {
        logic start;
        logic [1:0] rate;
    } cqc_probe_req_t;

    typedef struct packed {
        logic done;
        logic ok;
        logic [7:0] cycle_time;
    } cqc_probe_rsp_t;

endpackage

/* File: hw/cqc_wakeup.sv */
// Purpose: Wake-up pulse timer shared by host and sequencer requests
// Assumes: start is ignored while a pulse is running
// Notes:   done is a one-cycle pulse in the cycle after the pulse ends
`timescale 1ns/1ns
`default_nettype none
module cqc_wakeup #(
    parameter int CYCLES = cqc_pkg::CQC_WURQ_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    // Status
    output logic active,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic active;
        logic done;
        logic [CW-1:0] cnt;
    } cqc_wk_state_t;

    cqc_wk_state_t s_q;
    cqc_wk_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (s_q.active) begin
            if (s_q.cnt == LAST) begin
                s_d.active = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end else if (start) begin
            s_d.active = 1'b1;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign active = s_q.active;
    assign done = s_q.done;
endmodule
`default_nettype wire

/* File: hw/cqc_cycle_timer.sv */
// Purpose: Armed cycle timer, free running once started
// Assumes: period in ref_clk cycles, zero behaves as one
// Notes:   Dropping arm stops the count at once, mid cycle
`timescale 1ns/1ns
`default_nettype none
module cqc_cycle_timer #(
    parameter int W = cqc_pkg::CQC_TIMER_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic arm,
    input wire logic start,
    input wire logic [W-1:0] period,
    // Status
    output logic running,
    output logic tick
);
    typedef struct packed {
        logic running;
        logic tick;
        logic [W-1:0] cnt;
    } cqc_tmr_state_t;

    cqc_tmr_state_t s_q;
    cqc_tmr_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!arm) begin
            s_d.running = 1'b0;
            s_d.cnt = '0;
        end else if (s_q.running) begin
            if ({1'b0, s_q.cnt} + 1'b1 >= {1'b0, period}) begin
                s_d.tick = 1'b1;
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end else if (start) begin
            s_d.running = 1'b1;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign running = s_q.running;
    assign tick = s_q.tick;
endmodule
`default_nettype wire

/* File: testbench/cqc_framer_model.sv */
// Purpose: Framer stand-in answering link setup rate probes
// Assumes: one probe outstanding at a time
// Notes:   Fields churn while done is low, so stale data never looks valid
`timescale 1ns/1ns
`default_nettype none
module cqc_framer_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Device under test side
    input wire cqc_pkg::cqc_probe_req_t probe_req,
    output var cqc_pkg::cqc_probe_rsp_t probe_rsp,
    // Remote device setup, rate 0 fails every probe
    input wire logic [1:0] dev_rate,
    input wire logic [7:0] dev_cycle_time
);
    logic [3:0] wait_q;
    logic [1:0] rate_q;
    logic [7:0] junk_q;
    // ****************
    // Probe answer
    // ****************
    always @(posedge ref_clk) begin
        junk_q <= rst ? 8'h00 : junk_q + 8'h5B;
        probe_rsp.done <= 1'b0;
        probe_rsp.ok <= junk_q[0];
        probe_rsp.cycle_time <= ~junk_q;
        if (rst) begin
            wait_q <= 4'h0;
        end else if (probe_req.start) begin
            wait_q <= 4'h4;
            rate_q <= probe_req.rate;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
            if (wait_q == 4'h1) begin
                probe_rsp.done <= 1'b1;
                probe_rsp.ok <= (rate_q == dev_rate);
                if (rate_q == dev_rate) begin
                    probe_rsp.cycle_time <= dev_cycle_time;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/cq_channel_control_bench.sv */
// Purpose: Self-checking bench for the channel control register
// Assumes: short wake-up pulse parameter for run time
// Notes:   Outputs are sampled at the falling edge, inputs move on rising
`timescale 1ns/1ns
`default_nettype none
module cq_channel_control_bench;
    localparam int WQ = 10;
    logic ref_clk, rst, reg_wr, reg_rd, fen, txe, txb, trig, txclr, rxclr;
    logic run, tick, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, dct, rd_v, dev_ct;
    logic [1:0] dev_rate;
    logic [15:0] per;
    cqc_pkg::cqc_probe_rsp_t prsp;
    cqc_pkg::cqc_probe_req_t preq;
    cqc_pkg::cqc_line_t line;
    int miscompares, compares, n_tx, n_rx, n_wk, n_bo, n_irq, n_tk, b, bo;
    int rates[$] = '{3, 2, 1, 0};

    cqc_channel_ctrl #(.WURQ_CYCLES(WQ), .TIMER_W(16)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .framer_enable_bit(fen), .tx_queue_empty(txe), .tx_shift_busy(txb),
        .trigger_cmd(trig), .probe_rsp(prsp), .probe_req(preq),
        .transmit_queue_clear(txclr), .receive_queue_clear(rxclr),
        .line(line), .cycle_period(per), .timer_running(run),
        .cycle_tick(tick), .wakeup_done_interrupt(irq),
        .device_cycle_time_reg(dct));
    cqc_framer_model u_frm (.ref_clk(ref_clk), .rst(rst), .probe_req(preq),
        .probe_rsp(prsp), .dev_rate(dev_rate), .dev_cycle_time(dev_ct));

    // ****************
    // Clock and event counters
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        n_tx += int'(txclr === 1'b1);
        n_rx += int'(rxclr === 1'b1);
        n_wk += int'(line.wakeup_drive === 1'b1);
        n_bo += int'(line.climit_boost === 1'b1);
        n_irq += int'(irq === 1'b1);
        n_tk += int'(tick === 1'b1);
    end

    // ****************
    // Tasks
    // ****************
    task automatic chk(input string nm, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        cyc(2);
        rd_v = reg_rdata;
    endtask
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    // ****************
    // Tests
    // ****************
    initial begin
        {rst, fen, txe} = 3'b111;
        {reg_wr, reg_rd, txb, trig} = 4'h0;
        {reg_addr, reg_wdata, dev_ct, dev_rate} = '0;
        void'($urandom(87720));
        per = 16'(2 + $urandom % 4);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h06);
        chk("ctrl reset", 8'h00, rd_v);
        rd(8'h05);
        chk("unmapped", 8'h00, rd_v);
        chk("rx idle", 8'h01, 8'(line.rx_mode));
        $display("test reset done");
        wr(8'h05, 8'h0C);
        wr(8'h06, 8'h08);
        wr(8'h06, 8'h04);
        rd(8'h06);
        chk("clear bits", 8'h00, rd_v);
        chk("tx clears", 8'h01, 8'(n_tx));
        chk("rx clears", 8'h01, 8'(n_rx));
        $display("test queue clear done");
        @(posedge ref_clk);
        {txe, txb} <= 2'b01;
        wr(8'h06, 8'h01);
        rd(8'h06);
        chk("send bit", 8'h00, rd_v);
        chk("tx mode", 8'h01, 8'(line.tx_mode));
        chk("rx off", 8'h00, 8'(line.rx_mode));
        @(posedge ref_clk);
        {txe, txb} <= 2'b10;
        cyc(4);
        chk("tx end", 8'h00, 8'(line.tx_mode));
        chk("rx back", 8'h01, 8'(line.rx_mode));
        $display("test send done");
        wr(8'h06, 8'h02);
        cyc(20);
        chk("armed idle", 8'h00, 8'(run));
        b = n_tk;
        wr(8'h06, 8'h03);
        cyc(3);
        chk("send start", 8'h01, 8'(run));
        cyc(int'(per) * 8);
        chk("ticks", 8'h01, 8'(n_tk - b >= 7 && n_tk - b <= 10));
        wr(8'h06, 8'h00);
        cyc(3);
        chk("stopped", 8'h00, 8'(run));
        b = n_tk;
        cyc(20);
        chk("no ticks", 8'h00, 8'(n_tk - b));
        wr(8'h06, 8'h02);
        @(posedge ref_clk);
        trig <= 1'b1;
        @(posedge ref_clk);
        trig <= 1'b0;
        cyc(3);
        chk("trig start", 8'h01, 8'(run));
        wr(8'h06, 8'h00);
        $display("test timer done");
        b = n_wk;
        bo = n_bo;
        wr(8'h06, 8'h10);
        cyc(WQ + 4);
        chk("wake len", 8'(WQ), 8'(n_wk - b));
        chk("no boost", 8'h00, 8'(n_bo - bo));
        chk("rx after", 8'h01, 8'(line.rx_mode));
        rd(8'h06);
        chk("wake bit", 8'h00, rd_v);
        $display("test wake done");
        foreach (rates[i]) begin
            @(posedge ref_clk);
            dev_rate <= 2'(rates[i]);
            dev_ct <= 8'($urandom);
            b = n_irq;
            bo = n_bo;
            wr(8'h06, 8'h20);
            for (int k = 0; k < 400 && n_irq == b; k++) cyc(1);
            cyc(3);
            chk("irq", 8'h01, 8'(n_irq - b));
            chk("boost", 8'(WQ), 8'(n_bo - bo));
            rd(8'h06);
            chk("rate", {2'(rates[i]), 6'h00}, rd_v);
            if (rates[i] != 0) chk("cycle time", dev_ct, dct);
        end
        @(posedge ref_clk);
        fen <= 1'b0;
        b = n_wk;
        wr(8'h06, 8'h20);
        cyc(5);
        rd(8'h06);
        chk("no setup", 8'h00, rd_v);
        chk("no wake", 8'h00, 8'(n_wk - b));
        $display("test setup done");
        print_verdict();
    end
endmodule
`default_nettype wire
